// ---- include/vpm_params.svh ----
`ifndef VPM_PARAMS_SVH
`define VPM_PARAMS_SVH

// Register indices on the plain register port
`define VPM_ADDR_WIDTH        4
`define VPM_REG_PRIORITY      4'h0
`define VPM_REG_BACKGROUND    4'h1
`define VPM_REG_FIELD_0       4'h2
`define VPM_REG_FIELD_1       4'h3
`define VPM_REG_FIELD_2       4'h4
`define VPM_REG_FIELD_3       4'h5
`define VPM_REG_PLAYER_0      4'h6
`define VPM_REG_PLAYER_1      4'h7
`define VPM_REG_PLAYER_2      4'h8
`define VPM_REG_PLAYER_3      4'h9
`define VPM_REG_STATUS        4'hA

// priority_control fields
`define VPM_PRI_SEL_LSB       0
`define VPM_PRI_SEL_MSB       3
`define VPM_PRI_FIFTH_BIT     4
`define VPM_PRI_MULTI_BIT     5
`define VPM_PRI_SPECIAL_LSB   6
`define VPM_PRI_SPECIAL_MSB   7

// Select setting where the fifth player covers fields 0/1 that cover players
`define VPM_SEL_FIELD_SPLIT   4'h8

// Status fields
`define VPM_STAT_HIRES_BIT    0
`define VPM_STAT_SPECIAL_BIT  1

// Reset values
`define VPM_PRIORITY_RESET    8'h00
`define VPM_COLOR_RESET       8'h00
`define VPM_BLACK             8'h00

// Playfield codes from the display-fetch chip
`define VPM_CODE_BACKGROUND   3'h0
`define VPM_CODE_HIRES_FLAG   2

`endif

// ---- include/vpm_pkg.sv ----
package vpm_pkg;

   typedef logic [7:0] vpm_color_type;

   typedef enum logic [1:0] {
      VPM_MODE_NORMAL = 2'h0,
      VPM_MODE_LUMA16 = 2'h1,
      VPM_MODE_NINE   = 2'h2,
      VPM_MODE_HUE16  = 2'h3
   } vpm_special_type;

endpackage

// ---- core/vpm_mixer.sv ----
`timescale 1ns/1ps
`include "vpm_params.svh"

module vpm_mixer #(
   parameter int ADDR_WIDTH = `VPM_ADDR_WIDTH
) (
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire logic                   clock_enable,
   input  wire logic [ADDR_WIDTH-1:0]  reg_address,
   input  wire logic [7:0]             reg_write_data,
   input  wire logic                   reg_write,
   input  wire logic                   reg_read,
   output      logic [7:0]             reg_read_data,
   input  wire logic                   player_zero,
   input  wire logic                   player_one,
   input  wire logic                   player_two,
   input  wire logic                   player_three,
   input  wire logic [3:0]             missile,
   input  wire logic [2:0]             playfield_code,
   input  wire logic                   horizontal_blank,
   input  wire logic                   hires_request,
   output      vpm_pkg::vpm_color_type pixel_color_first,
   output      vpm_pkg::vpm_color_type pixel_color_second,
   output      logic [3:0]             collision_player,
   output      logic [3:0]             collision_missile,
   output      logic [3:0]             collision_field,
   output      logic                   hires_collision_signal
);

   logic [7:0]             priority_control;
   vpm_pkg::vpm_color_type background_color;
   vpm_pkg::vpm_color_type field_color [4];
   vpm_pkg::vpm_color_type player_color [4];
   logic                   hires_line;
   logic [1:0]             previous_pair;

   // Replaces the luminance nibble of a color with that of field_color_1
   function automatic vpm_pkg::vpm_color_type luma_swap(input vpm_pkg::vpm_color_type base,
                                                        input logic pixel_on,
                                                        input vpm_pkg::vpm_color_type luma);
      luma_swap = pixel_on ? {base[7:4], luma[3:0]} : base;
   endfunction

   // Low-resolution decode of a playfield code into field color activity
   function automatic logic [3:0] decode_field(input logic [2:0] code);
      decode_field = 4'h0;
      if (code[`VPM_CODE_HIRES_FLAG]) begin
         decode_field[code[1:0]] = 1'b1;
      end
   endfunction

   // Register port
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         priority_control <= `VPM_PRIORITY_RESET;
         background_color <= `VPM_COLOR_RESET;
         for (int i = 0; i < 4; i++) begin
            field_color[i]  <= `VPM_COLOR_RESET;
            player_color[i] <= `VPM_COLOR_RESET;
         end
      end else if (clock_enable && reg_write) begin
         case (reg_address)
            `VPM_REG_PRIORITY:   priority_control <= reg_write_data;
            `VPM_REG_BACKGROUND: background_color <= reg_write_data;
            `VPM_REG_FIELD_0:    field_color[0] <= reg_write_data;
            `VPM_REG_FIELD_1:    field_color[1] <= reg_write_data;
            `VPM_REG_FIELD_2:    field_color[2] <= reg_write_data;
            `VPM_REG_FIELD_3:    field_color[3] <= reg_write_data;
            `VPM_REG_PLAYER_0:   player_color[0] <= reg_write_data;
            `VPM_REG_PLAYER_1:   player_color[1] <= reg_write_data;
            `VPM_REG_PLAYER_2:   player_color[2] <= reg_write_data;
            `VPM_REG_PLAYER_3:   player_color[3] <= reg_write_data;
            default: begin
            end
         endcase
      end
   end

   logic [1:0] special_bits;
   logic       special_on;
   assign special_bits = priority_control[`VPM_PRI_SPECIAL_MSB:`VPM_PRI_SPECIAL_LSB];
   assign special_on   = |special_bits;

   // Only the status register reads back; priority and color registers are write-only
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_read_data <= 8'h00;
      end else if (clock_enable) begin
         reg_read_data <= 8'h00;
         if (reg_read) begin
            case (reg_address)
               `VPM_REG_STATUS: begin
                  reg_read_data[`VPM_STAT_HIRES_BIT]   <= hires_line;
                  reg_read_data[`VPM_STAT_SPECIAL_BIT] <= special_on;
               end
               default: reg_read_data <= 8'h00;
            endcase
         end
      end
   end

   // High-resolution flip-flop
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hires_line <= 1'b0;
      end else if (clock_enable) begin
         if (special_on) begin
            hires_line <= 1'b0;
         end else if (horizontal_blank) begin
            hires_line <= hires_request;
         end
      end
   end

   // Playfield pair of the previous clock, forms four-bit special-mode pixels
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         previous_pair <= 2'h0;
      end else if (clock_enable) begin
         previous_pair <= playfield_code[1:0];
      end
   end

   // Priority resolution
   logic       fifth_on;
   logic       multi_on;
   logic [3:0] sel;
   logic       pri01;
   logic       pri12;
   logic       pri23;
   logic       pri03;
   logic       hires_active;
   logic [3:0] field_raw;
   logic       grp0;
   logic       grp1;
   logic       grp2;
   logic       grp3;
   logic       fifth;
   logic       p01;
   logic       p23;
   logic       pf0;
   logic       pf1;
   logic       pf2;
   logic       pf3;
   logic       pf01;
   logic       pf23;
   logic       sp0;
   logic       sp1;
   logic       sp2;
   logic       sp3;
   logic       sf0;
   logic       sf1;
   logic       sf2;
   logic       sf3;
   logic       sb;
   logic [3:0] special_nibble;
   vpm_pkg::vpm_color_type mixed;
   vpm_pkg::vpm_color_type next_color;

   assign fifth_on     = priority_control[`VPM_PRI_FIFTH_BIT];
   assign multi_on     = priority_control[`VPM_PRI_MULTI_BIT];
   assign sel          = priority_control[`VPM_PRI_SEL_MSB:`VPM_PRI_SEL_LSB];
   assign pri01        = sel[0] | sel[1];
   assign pri12        = sel[1] | sel[2];
   assign pri23        = sel[2] | sel[3];
   assign pri03        = sel[0] | sel[3];
   assign hires_active = hires_line & ~special_on;

   always_comb begin
      field_raw = decode_field(playfield_code);
      if (hires_active) begin
         field_raw = playfield_code[`VPM_CODE_HIRES_FLAG] ? 4'h4 : 4'h0;
      end
   end

   // Missiles join player groups unless the fifth player takes them
   assign grp0  = player_zero  | (missile[0] & ~fifth_on);
   assign grp1  = player_one   | (missile[1] & ~fifth_on);
   assign grp2  = player_two   | (missile[2] & ~fifth_on);
   assign grp3  = player_three | (missile[3] & ~fifth_on);
   assign fifth = fifth_on & (|missile);
   assign p01   = grp0 | grp1;
   assign p23   = grp2 | grp3;
   assign pf0   = field_raw[0];
   assign pf1   = field_raw[1];
   assign pf2   = field_raw[2];
   assign pf3   = field_raw[3] | fifth;
   assign pf01  = pf0 | pf1;
   assign pf23  = pf2 | pf3;

   // With sel clear these reduce to the mode-0 terms
   assign sp0 = grp0 & ~(pf01 & pri23) & ~(sel[2] & pf23);
   assign sp1 = grp1 & ~(pf01 & pri23) & ~(sel[2] & pf23)
                & (~grp0 | multi_on);
   assign sp2 = grp2 & ~p01 & ~(pf23 & pri12) & ~(pf01 & ~sel[0]);
   assign sp3 = grp3 & ~p01 & ~(pf23 & pri12) & ~(pf01 & ~sel[0])
                & (~grp2 | multi_on);
   // Fifth player outranks fields 0/1, and with sel at VPM_SEL_FIELD_SPLIT also where those fields hide the players
   assign sf3 = (pf3 & ~(p23 & pri03) & ~(p01 & ~sel[2]))
                | (fifth & pf01 & (p01 | p23) & (sel == `VPM_SEL_FIELD_SPLIT));
   assign sf0 = pf0 & ~(p23 & sel[0]) & ~(p01 & pri01) & ~sf3;
   assign sf1 = pf1 & ~(p23 & sel[0]) & ~(p01 & pri01) & ~sf3;
   assign sf2 = pf2 & ~(p23 & pri03) & ~(p01 & ~sel[2]) & ~sf3;
   assign sb  = ~p01 & ~p23 & ~pf01 & ~pf23;

   always_comb begin
      mixed = `VPM_BLACK;
      if (sp0) begin
         mixed = mixed | player_color[0];
      end
      if (sp1) begin
         mixed = mixed | player_color[1];
      end
      if (sp2) begin
         mixed = mixed | player_color[2];
      end
      if (sp3) begin
         mixed = mixed | player_color[3];
      end
      if (sf0) begin
         mixed = mixed | field_color[0];
      end
      if (sf1) begin
         mixed = mixed | field_color[1];
      end
      if (sf2) begin
         mixed = mixed | field_color[2];
      end
      if (sf3) begin
         mixed = mixed | field_color[3];
      end
      if (sb) begin
         mixed = background_color;
      end
   end

   // Special luma and hue modes: fifth player skips the player-protection check
   assign special_nibble = {previous_pair, playfield_code[1:0]};

   always_comb begin
      next_color = mixed;
      case (vpm_pkg::vpm_special_type'(special_bits))
         vpm_pkg::VPM_MODE_LUMA16: begin
            if (fifth) begin
               next_color = {field_color[3][7:4], special_nibble};
            end
         end
         vpm_pkg::VPM_MODE_HUE16: begin
            if (fifth) begin
               next_color = (special_nibble == 4'h0) ? `VPM_BLACK
                            : {special_nibble, field_color[3][3:0]};
            end
         end
         default: next_color = mixed;
      endcase
   end

   // Registered output, one resolution per color clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pixel_color_first  <= `VPM_BLACK;
         pixel_color_second <= `VPM_BLACK;
      end else if (clock_enable) begin
         pixel_color_first  <= luma_swap(next_color,
                               hires_active & playfield_code[1], field_color[1]);
         pixel_color_second <= luma_swap(next_color,
                               hires_active & playfield_code[0], field_color[1]);
      end
   end

   // Collision feed: raw object activity, independent of fifth-player and multicolor
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         collision_player       <= 4'h0;
         collision_missile      <= 4'h0;
         collision_field        <= 4'h0;
         hires_collision_signal <= 1'b0;
      end else if (clock_enable) begin
         collision_player  <= {player_three, player_two, player_one, player_zero};
         collision_missile <= missile;
         if (hires_active) begin
            collision_field        <= {1'b0, playfield_code[`VPM_CODE_HIRES_FLAG]
                                      & (|playfield_code[1:0]), 2'h0};
            hires_collision_signal <= playfield_code[`VPM_CODE_HIRES_FLAG]
                                      & (|playfield_code[1:0]);
         end else begin
            collision_field        <= decode_field(playfield_code);
            hires_collision_signal <= 1'b0;
         end
      end
   end

endmodule

// ---- testbench/vpm_mixer_checker.sv ----
`timescale 1ns/1ps
module vpm_mixer_checker (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       clock_enable,
   input wire logic [3:0] reg_address,
   input wire logic [7:0] reg_write_data,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_read_data,
   input wire logic       player_zero,
   input wire logic       player_one,
   input wire logic       player_two,
   input wire logic       player_three,
   input wire logic [3:0] missile,
   input wire logic [2:0] playfield_code,
   input wire logic       horizontal_blank,
   input wire logic       hires_request,
   input wire logic [7:0] pixel_color_first,
   input wire logic [7:0] pixel_color_second,
   input wire logic [3:0] collision_player,
   input wire logic [3:0] collision_missile,
   input wire logic [3:0] collision_field,
   input wire logic       hires_collision_signal
);
   logic [7:0] prio;
   logic       hf;
   wire        special = |prio[7:6];
   wire  [3:0] pl      = {player_three, player_two, player_one, player_zero};
   wire        hc      = hf && !special && |playfield_code[1:0];
   wire  [3:0] fld     = (hf && !special) ? {1'b0, hc, 2'h0}
                         : (playfield_code[2] ? 4'h1 << playfield_code[1:0] : 4'h0);
   // Shadow of the priority register and the line's hires flag
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prio <= 8'h00;
      end else if (clock_enable && reg_write && reg_address == 4'h0) begin
         prio <= reg_write_data;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hf <= 1'b0;
      end else if (clock_enable && special) begin
         hf <= 1'b0;
      end else if (clock_enable && horizontal_blank) begin
         hf <= hires_request;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   status_read_a: assert property (clock_enable && reg_read && reg_address == 4'hA |=>
      reg_read_data == {6'h00, $past(special), $past(hf)}) else $error("status read wrong");
   wo_read_a: assert property (clock_enable && reg_read && reg_address != 4'hA |=>
      reg_read_data == 8'h00) else $error("write-only read not zero");
   miss_coll_a: assert property (clock_enable |=> collision_missile == $past(missile))
      else $error("missile collision wrong");
   play_coll_a: assert property (clock_enable |=> collision_player == $past(pl))
      else $error("player collision wrong");
   hires_coll_a: assert property (clock_enable && !horizontal_blank |=>
      hires_collision_signal == $past(hc)) else $error("hires collision wrong");
   field_coll_a: assert property (clock_enable |=> collision_field == $past(fld))
      else $error("field collision wrong");
   hires_kill_a: assert property (clock_enable && special && !horizontal_blank ##1
      clock_enable && !special && !horizontal_blank |=> !hires_collision_signal)
      else $error("hires flag revived mid-line");
   freeze_out_a: assert property (!clock_enable |=> $stable(pixel_color_first)
      && $stable(pixel_color_second)) else $error("pixel moved while frozen");
   lowres_halves_a: assert property (clock_enable && !(hf && !special) |=>
      pixel_color_first == pixel_color_second) else $error("halves differ");
   cover property (hires_collision_signal);
   cover property (clock_enable && special);
   cover property (!clock_enable);
endmodule

bind vpm_mixer vpm_mixer_checker i_vpm_mixer_checker (.*);

// ---- testbench/vpm_fetch_model.sv ----
`timescale 1ns/1ps
module vpm_fetch_model (
   input  wire logic       hires_line,
   input  wire logic [1:0] pixel,
   output      logic [2:0] code,
   output      logic       hires_indication
);
   always_comb begin
      if (hires_line) begin
         code = {1'b1, pixel};
      end else if (pixel == 2'h0) begin
         code = 3'h0;
      end else begin
         code = {1'b1, pixel - 2'h1};
      end
   end
   assign hires_indication = hires_line;
endmodule

// ---- testbench/vpm_mixer_tb.sv ----
`timescale 1ns/1ps
module vpm_mixer_tb;
   typedef struct packed {
      logic [7:0] prio;
      logic [3:0] pl;
      logic [3:0] ms;
      logic [1:0] pix;
      logic [8:0] mask;
   } vpm_row_type;
   logic        clock, rst, clock_enable, reg_write, reg_read, hires_line;
   logic        horizontal_blank, hires_request, hires_col;
   logic [3:0]  reg_address, pl, missile;
   logic [7:0]  reg_write_data, reg_read_data, pixel_first, pixel_second;
   logic [1:0]  pix;
   logic [2:0]  playfield_code;
   int          err_total, check_count, cycles;
   // Order: background, fields 0-3, players 0-3
   logic [7:0]  col [9] = '{8'h80, 8'h40, 8'h2C, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'hA0};
   vpm_row_type rows [19] = '{
      '{8'h00, 4'h1, 4'h0, 2'h1, 9'h022},
      '{8'h00, 4'h3, 4'h0, 2'h0, 9'h020},
      '{8'h20, 4'h3, 4'h0, 2'h0, 9'h060},
      '{8'h00, 4'h4, 4'h0, 2'h1, 9'h002},
      '{8'h00, 4'h1, 4'h0, 2'h3, 9'h020},
      '{8'h00, 4'h4, 4'h0, 2'h3, 9'h088},
      '{8'h03, 4'h1, 4'h0, 2'h1, 9'h020},
      '{8'h0C, 4'h1, 4'h0, 2'h1, 9'h002},
      '{8'h05, 4'h1, 4'h0, 2'h1, 9'h000},
      '{8'h01, 4'h4, 4'h0, 2'h3, 9'h080},
      '{8'h08, 4'h1, 4'h0, 2'h1, 9'h002},
      '{8'h10, 4'h0, 4'h1, 2'h0, 9'h010},
      '{8'h00, 4'h0, 4'h1, 2'h3, 9'h020},
      '{8'h18, 4'h1, 4'h1, 2'h1, 9'h010},
      '{8'h05, 4'h5, 4'h0, 2'h0, 9'h020},
      '{8'h00, 4'h2, 4'h0, 2'h2, 9'h044},
      '{8'h13, 4'h1, 4'h1, 2'h0, 9'h020},
      '{8'h03, 4'h4, 4'h0, 2'h3, 9'h000},
      '{8'h20, 4'h0, 4'h3, 2'h0, 9'h060}
   };

   vpm_mixer i_vpm_mixer (
      .clock                  (clock),
      .rst                    (rst),
      .clock_enable           (clock_enable),
      .reg_address            (reg_address),
      .reg_write_data         (reg_write_data),
      .reg_write              (reg_write),
      .reg_read               (reg_read),
      .reg_read_data          (reg_read_data),
      .player_zero            (pl[0]),
      .player_one             (pl[1]),
      .player_two             (pl[2]),
      .player_three           (pl[3]),
      .missile                (missile),
      .playfield_code         (playfield_code),
      .horizontal_blank       (horizontal_blank),
      .hires_request          (hires_request),
      .pixel_color_first      (pixel_first),
      .pixel_color_second     (pixel_second),
      .collision_player       (),
      .collision_missile      (),
      .collision_field        (),
      .hires_collision_signal (hires_col)
   );
   vpm_fetch_model i_vpm_fetch_model (
      .hires_line       (hires_line),
      .pixel            (pix),
      .code             (playfield_code),
      .hires_indication (hires_request)
   );

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         results();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_address <= a;
      reg_write_data <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_address <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(reg_read_data, exp);
   endtask
   task automatic px(input logic [7:0] e1, input logic [7:0] e2);
      @(posedge clock);
      #1;
      chk(pixel_first, e1);
      chk(pixel_second, e2);
   endtask
   function automatic logic [7:0] mix(input logic [8:0] m);
      mix = 8'h00;
      for (int i = 0; i < 9; i++) begin
         if (m[i]) mix |= col[i];
      end
   endfunction

   initial begin
      {rst, clock_enable} = 2'b11;
      {reg_write, reg_read, hires_line, horizontal_blank} = 4'h0;
      {reg_address, pl, missile, pix, reg_write_data} = 22'h0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk(pixel_first, 8'h00);
      rd(4'hA, 8'h00);
      rd(4'hF, 8'h00);
      rd(4'h0, 8'h00);
      for (int i = 0; i < 9; i++) begin
         wr(4'(i + 1), col[i]);
      end
      foreach (rows[i]) begin
         wr(4'h0, rows[i].prio);
         pl <= rows[i].pl;
         missile <= rows[i].ms;
         pix <= rows[i].pix;
         px(mix(rows[i].mask), mix(rows[i].mask));
      end
      wr(4'h0, 8'h00);
      {pl, missile, pix} <= 10'h0;
      hires_line <= 1'b1;
      horizontal_blank <= 1'b1;
      @(posedge clock);
      horizontal_blank <= 1'b0;
      rd(4'hA, 8'h01);
      pix <= 2'h2;
      px({col[3][7:4], col[2][3:0]}, col[3]);
      chk({7'h00, hires_col}, 8'h01);
      pl <= 4'h1;
      pix <= 2'h3;
      px({col[5][7:4], col[2][3:0]}, {col[5][7:4], col[2][3:0]});
      pl <= 4'h0;
      wr(4'h0, 8'h40);
      wr(4'h0, 8'h00);
      rd(4'hA, 8'h00);
      px(col[4], col[4]);
      chk({7'h00, hires_col}, 8'h00);
      clock_enable <= 1'b0;
      pl <= 4'hF;
      px(col[4], col[4]);
      clock_enable <= 1'b1;
      pl <= 4'h0;
      missile <= 4'h1;
      pix <= 2'h2;
      wr(4'h0, 8'h50);
      pix <= 2'h1;
      px({col[4][7:4], 4'h9}, {col[4][7:4], 4'h9});
      wr(4'h0, 8'hD0);
      pix <= 2'h3;
      px({4'h7, col[4][3:0]}, {4'h7, col[4][3:0]});
      pix <= 2'h0;
      px({4'hC, col[4][3:0]}, {4'hC, col[4][3:0]});
      px(8'h00, 8'h00);
      results();
   end
endmodule
